// file: design/flit_map.svh
// Bit positions, format codes and message widths for the flit slot packer.
`ifndef FLIT_MAP_SVH
`define FLIT_MAP_SVH

`define SLOT_BITS 128
`define SLOTS_PER_FLIT 3'h4
`define LAST_SLOT 2'h3
`define HDR_BITS 8'h20
`define NO_HDR_BITS 8'h00
`define BYTE_BITS 8'h08

// Flit header field positions inside the first bytes of slot 0.
`define HDR_TYPE_BIT 0
`define HDR_ACK_BIT 1
`define HDR_BE_BIT 2
`define HDR_SZ_BIT 3
`define HDR_FMT_LSB 4
`define HDR_FMT_W 3
`define HDR_REQCRD_LSB 16
`define HDR_RSPCRD_LSB 20
`define HDR_DATACRD_LSB 24
`define HDR_CRD_W 4

// Header slot format codes.
`define FMT_H0 3'h0
`define FMT_H1 3'h1
`define FMT_H2 3'h2
`define FMT_H3 3'h3
`define FMT_H4 3'h4
`define FMT_H5 3'h5

// Message widths in bits, inbound (host to device, host to memory).
`define W_NONE 7'h00
`define W_H2D_REQ 7'h40
`define W_H2D_RSP 7'h20
`define W_H2D_DH 7'h18
`define W_M2S_RWD 7'h50
`define W_M2S_REQ 7'h48
// Message widths in bits, outbound (device to host, memory to host).
`define W_D2H_REQ 7'h40
`define W_D2H_DH 7'h14
`define W_D2H_RSP 7'h10
`define W_S2M_NDR 7'h1C
`define W_S2M_DRS 7'h28
// Fourth data header with the response packed right above it, in one lane.
`define W_D2H_DH_RSP 7'h24

// Byte starts of the two responses of inbound H1.
`define H1_RSP0_BYTE 8'h07
`define H1_RSP1_BYTE 8'h0B

// Address field of a memory request: bits 51 down to 5.
`define M2S_ADDR_LSB 8
`define M2S_ADDR_W 47
`define ADDR_LOW_ZERO 5'h00

`endif

// file: design/flit_pkg.sv
// Types carried by the flit slot packer.
package flit_pkg;

  typedef logic [127:0] slot_t;
  typedef logic [95:0] msg_t;
  typedef logic [3:0][6:0] lane_w_t;
  typedef logic [3:0][7:0] lane_s_t;

  typedef struct packed {
    logic flit_type;
    logic ack;
    logic be;
    logic sz;
    logic [3:0][2:0] slot_fmt;
    logic [3:0] req_crd;
    logic [3:0] rsp_crd;
    logic [3:0] data_crd;
  } flit_hdr_t;

  typedef struct packed {
    flit_hdr_t hdr;
    msg_t [3:0] msg;
  } slot_req_t;

  typedef struct packed {
    flit_hdr_t hdr;
    logic [1:0] slot_idx;
    logic fmt_err;
    logic [3:0] lane_valid;
    msg_t [3:0] msg;
    logic [7:0] first_seq;
    logic addr_valid;
    logic [51:0] addr;
  } slot_msgs_t;

endpackage : flit_pkg

// file: design/flit_slot_packer.sv
// Packer for outbound slots and parser for inbound slots of the flit link.
// Contract
// - Slot bits run byte 0 bit 0 to byte 15 bit 7.
// - Field low bits sit at low slot positions.
// - Lower flit positions carry earlier messages.
// - Snoop in slot 1 follows response in slot 0.
// - Inbound H1 response at byte 7 precedes byte 11.
// - Inbound H0-H3 carry their documented message sets.
// - Inbound H4 one data-write header, H5 one request.
// - Outbound H0-H2 carry their documented message sets.
// - Outbound H3-H5 carry their memory-response sets.
// - Memory request carries address bits 51 to 5.
`timescale 1ns/1ps
`default_nettype none
`include "flit_map.svh"

module flit_slot_packer
  import flit_pkg::*;
(
  input wire logic ref_clk, // Link-layer clock, 125 MHz.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic tx_valid, // Outbound slot request offered.
  output logic tx_ready, // Outbound slot request taken.
  input wire slot_req_t tx_req, // Flit header and up to five messages in four lanes.
  output logic tx_slot_valid, // Packed slot ready for the link.
  input wire logic tx_slot_ready, // Link takes the packed slot.
  output slot_t tx_slot, // Packed 16-byte slot.
  input wire logic rx_slot_valid, // Inbound slot offered.
  output logic rx_slot_ready, // Inbound slot taken.
  input wire slot_t rx_slot, // Inbound 16-byte slot.
  output logic rx_msgs_valid, // Parsed slot available.
  input wire logic rx_msgs_ready, // User takes the parsed slot.
  output slot_msgs_t rx_msgs // Parsed messages in arrival order.
);

  // Lane widths for one direction and format; a zero width means no lane.
  function automatic lane_w_t lane_widths(input logic inbound, input logic [2:0] fmt);
    lane_w_t w;
    w = '0;
    if (inbound)
    begin
      case (fmt)
        `FMT_H0: w = {`W_NONE, `W_NONE, `W_H2D_RSP, `W_H2D_REQ};
        `FMT_H1: w = {`W_NONE, `W_H2D_RSP, `W_H2D_RSP, `W_H2D_DH};
        `FMT_H2: w = {`W_NONE, `W_NONE, `W_H2D_DH, `W_H2D_REQ};
        `FMT_H3: w = {`W_H2D_DH, `W_H2D_DH, `W_H2D_DH, `W_H2D_DH};
        `FMT_H4: w = {`W_NONE, `W_NONE, `W_NONE, `W_M2S_RWD};
        `FMT_H5: w = {`W_NONE, `W_NONE, `W_NONE, `W_M2S_REQ};
        default: w = '0;
      endcase
    end
    else
    begin
      case (fmt)
        `FMT_H0: w = {`W_S2M_NDR, `W_D2H_RSP, `W_D2H_RSP, `W_D2H_DH};
        `FMT_H1: w = {`W_NONE, `W_NONE, `W_D2H_DH, `W_D2H_REQ};
        // Four lanes cannot hold five messages, so lane 3 carries the fourth data
        // header in its low bits and the response directly above it.
        `FMT_H2: w = {`W_D2H_DH_RSP, `W_D2H_DH, `W_D2H_DH, `W_D2H_DH};
        `FMT_H3: w = {`W_NONE, `W_NONE, `W_S2M_NDR, `W_S2M_DRS};
        `FMT_H4: w = {`W_NONE, `W_NONE, `W_S2M_NDR, `W_S2M_NDR};
        `FMT_H5: w = {`W_NONE, `W_NONE, `W_S2M_DRS, `W_S2M_DRS};
        default: w = '0;
      endcase
    end
    return w;
  endfunction : lane_widths

  // Lanes follow each other upward from the base, so lane order is message order.
  function automatic lane_s_t lane_starts(input lane_w_t w, input logic [7:0] base);
    lane_s_t s;
    s = '0;
    s[0] = base;
    for (int i = 1; i < 4; i++)
    begin
      s[i] = s[i-1] + {1'b0, w[i-1]};
    end
    return s;
  endfunction : lane_starts

  // Mask of the low w bits; bit 0 of a field lands on the lowest slot bit.
  function automatic slot_t low_mask(input logic [6:0] w);
    return (slot_t'(1) << w) - slot_t'(1);
  endfunction : low_mask

  function automatic logic [31:0] pack_hdr(input flit_hdr_t h);
    logic [31:0] v;
    v = '0;
    v[`HDR_TYPE_BIT] = h.flit_type;
    v[`HDR_ACK_BIT] = h.ack;
    v[`HDR_BE_BIT] = h.be;
    v[`HDR_SZ_BIT] = h.sz;
    for (int i = 0; i < 4; i++)
    begin
      v[`HDR_FMT_LSB + i*`HDR_FMT_W +: `HDR_FMT_W] = h.slot_fmt[i];
    end
    v[`HDR_REQCRD_LSB +: `HDR_CRD_W] = h.req_crd;
    v[`HDR_RSPCRD_LSB +: `HDR_CRD_W] = h.rsp_crd;
    v[`HDR_DATACRD_LSB +: `HDR_CRD_W] = h.data_crd;
    return v;
  endfunction : pack_hdr

  function automatic flit_hdr_t unpack_hdr(input logic [31:0] v);
    flit_hdr_t h;
    h = '0;
    h.flit_type = v[`HDR_TYPE_BIT];
    h.ack = v[`HDR_ACK_BIT];
    h.be = v[`HDR_BE_BIT];
    h.sz = v[`HDR_SZ_BIT];
    for (int i = 0; i < 4; i++)
    begin
      h.slot_fmt[i] = v[`HDR_FMT_LSB + i*`HDR_FMT_W +: `HDR_FMT_W];
    end
    h.req_crd = v[`HDR_REQCRD_LSB +: `HDR_CRD_W];
    h.rsp_crd = v[`HDR_RSPCRD_LSB +: `HDR_CRD_W];
    h.data_crd = v[`HDR_DATACRD_LSB +: `HDR_CRD_W];
    return h;
  endfunction : unpack_hdr

  // Outbound path. Slot 0 of a flit carries the flit header; its format codes
  // are kept so that slots 1 to 3 of the same flit use their own layouts.
  logic [1:0] tx_pos_q;
  logic [3:0][2:0] tx_fmts_q;
  wire tx_take = tx_valid && tx_ready;
  wire tx_first = (tx_pos_q == 2'h0);
  wire [2:0] tx_fmt = tx_first ? tx_req.hdr.slot_fmt[0] : tx_fmts_q[tx_pos_q];
  wire [7:0] tx_base = tx_first ? `HDR_BITS : `NO_HDR_BITS;
  wire lane_w_t tx_w = lane_widths(1'b0, tx_fmt);
  wire lane_s_t tx_s = lane_starts(tx_w, tx_base);
  slot_t tx_lane [4];
  slot_t tx_packed;

  // Each message goes into its lane with its low bit at the lane start.
  for (genvar g = 0; g < 4; g++)
  begin : g_tx_lane
    assign tx_lane[g] = (slot_t'(tx_req.msg[g]) & low_mask(tx_w[g])) << tx_s[g];
  end

  // Byte k bit b of the slot is bit 8*k+b of the vector.
  assign tx_packed = (tx_first ? slot_t'(pack_hdr(tx_req.hdr)) : '0)
    | tx_lane[0] | tx_lane[1] | tx_lane[2] | tx_lane[3];

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_pos_q <= 2'h0;
      tx_fmts_q <= '0;
    end
    else if (tx_take)
    begin
      tx_pos_q <= tx_pos_q + 2'h1;
      if (tx_first)
      begin
        tx_fmts_q <= tx_req.hdr.slot_fmt;
      end
    end
  end

  pair_buffer #(
    .WIDTH(`SLOT_BITS)
  ) u_tx_buf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_packed),
    .out_valid(tx_slot_valid),
    .out_ready(tx_slot_ready),
    .out_data(tx_slot)
  );

  // Inbound path. Slots are parsed in arrival order and never reordered, so a
  // snoop in slot 1 always leaves after the response of slot 0.
  logic [1:0] rx_pos_q;
  logic [3:0][2:0] rx_fmts_q;
  logic [7:0] rx_seq_q;
  wire rx_take = rx_slot_valid && rx_slot_ready;
  wire rx_first = (rx_pos_q == 2'h0);
  wire flit_hdr_t rx_hdr = unpack_hdr(rx_slot[31:0]);
  wire [2:0] rx_fmt = rx_first ? rx_hdr.slot_fmt[0] : rx_fmts_q[rx_pos_q];
  wire [7:0] rx_base = rx_first ? `HDR_BITS : `NO_HDR_BITS;
  wire lane_w_t rx_w = lane_widths(1'b1, rx_fmt);
  wire lane_s_t rx_s = lane_starts(rx_w, rx_base);
  wire rx_bad_fmt = (rx_fmt > `FMT_H5);
  msg_t rx_lane [4];
  logic [3:0] rx_lane_valid;
  logic [2:0] rx_count;
  slot_msgs_t rx_parsed;

  for (genvar g = 0; g < 4; g++)
  begin : g_rx_lane
    // In slot 0, lane 1 of inbound H1 starts at byte 7 and lane 2 at byte 11.
    assign rx_lane[g] = msg_t'((rx_slot >> rx_s[g]) & low_mask(rx_w[g]));
    assign rx_lane_valid[g] = (rx_w[g] != `W_NONE);
  end

  assign rx_count = 3'(rx_lane_valid[0]) + 3'(rx_lane_valid[1])
    + 3'(rx_lane_valid[2]) + 3'(rx_lane_valid[3]);

  always_comb
  begin
    rx_parsed = '0;
    rx_parsed.hdr = rx_first ? rx_hdr : '0;
    rx_parsed.slot_idx = rx_pos_q;
    rx_parsed.fmt_err = rx_bad_fmt;
    rx_parsed.lane_valid = rx_lane_valid;
    rx_parsed.msg = {rx_lane[3], rx_lane[2], rx_lane[1], rx_lane[0]};
    rx_parsed.first_seq = rx_seq_q;
    rx_parsed.addr_valid = (rx_fmt == `FMT_H5);
    rx_parsed.addr = {rx_lane[0][`M2S_ADDR_LSB +: `M2S_ADDR_W], `ADDR_LOW_ZERO};
  end

  // The sequence number counts messages, so lane order and slot order agree.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_pos_q <= 2'h0;
      rx_fmts_q <= '0;
      rx_seq_q <= 8'h00;
    end
    else if (rx_take)
    begin
      rx_pos_q <= rx_pos_q + 2'h1;
      rx_seq_q <= rx_seq_q + {5'h00, rx_count};
      if (rx_first)
      begin
        rx_fmts_q <= rx_hdr.slot_fmt;
      end
    end
  end

  pair_buffer #(
    .WIDTH($bits(slot_msgs_t))
  ) u_rx_buf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(rx_slot_valid),
    .in_ready(rx_slot_ready),
    .in_data(rx_parsed),
    .out_valid(rx_msgs_valid),
    .out_ready(rx_msgs_ready),
    .out_data(rx_msgs)
  );

endmodule : flit_slot_packer

`default_nettype wire

// file: design/pair_buffer.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module pair_buffer #(
  parameter int WIDTH = 128
) (
  input wire logic ref_clk, // Link-layer clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic in_valid, // Word offered.
  output logic in_ready, // Room for a word.
  input wire logic [WIDTH-1:0] in_data, // Word in.
  output logic out_valid, // Word held.
  input wire logic out_ready, // Receiver takes the word.
  output logic [WIDTH-1:0] out_data // Oldest word, from flip-flops.
);

  logic [WIDTH-1:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Full only at two words, so a stalled receiver back-pressures the source.
  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : pair_buffer

`default_nettype wire

// file: testbench/flit_slot_packer_sva.sv
// Concurrent checks on the ports of the flit slot packer.
`timescale 1ns/1ps
`default_nettype none

module flit_slot_packer_sva
  import flit_pkg::*;
(
  input wire logic ref_clk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic tx_valid, // Request offered.
  input wire logic tx_ready, // Request taken.
  input wire logic tx_slot_valid, // Slot held.
  input wire logic tx_slot_ready, // Slot taken.
  input wire slot_t tx_slot, // Packed slot.
  input wire logic rx_slot_valid, // Slot offered.
  input wire logic rx_slot_ready, // Slot taken.
  input wire logic rx_msgs_valid, // Parse held.
  input wire logic rx_msgs_ready, // Parse taken.
  input wire slot_msgs_t rx_msgs // Parsed slot.
);
  logic [1:0] tn_q;
  logic [1:0] rn_q;
  logic [7:0] sq_q;

  // Flit positions as slots leave at tx_slot and rx_msgs, and the message count as parsed slots leave at rx_msgs.
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      tn_q <= 2'h0;
      rn_q <= 2'h0;
      sq_q <= 8'h00;
    end
    else
    begin
      if (tx_slot_valid && tx_slot_ready)
        tn_q <= tn_q + 2'h1;
      if (rx_msgs_valid && rx_msgs_ready)
      begin
        rn_q <= rn_q + 2'h1;
        sq_q <= rx_msgs.first_seq + 8'($countones(rx_msgs.lane_valid));
      end
    end

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  property p_tx_ans;
    tx_valid && tx_ready && !tx_slot_valid |=> tx_slot_valid;
  endproperty
  a_tx_ans: assert property (p_tx_ans) else $error("tx slot late");
  property p_tx_hold;
    tx_slot_valid && !tx_slot_ready |=> tx_slot_valid && $stable(tx_slot);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx slot moved");
  property p_rx_ans;
    rx_slot_valid && rx_slot_ready && !rx_msgs_valid |=> rx_msgs_valid;
  endproperty
  a_rx_ans: assert property (p_rx_ans) else $error("rx parse late");
  property p_rx_hold;
    rx_msgs_valid && !rx_msgs_ready |=> rx_msgs_valid && $stable(rx_msgs);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx parse moved");
  property p_tx_hdr;
    tx_slot_valid && tn_q == 2'h0 |-> tx_slot[31:28] == 4'h0;
  endproperty
  a_tx_hdr: assert property (p_tx_hdr) else $error("header spare set");
  property p_rx_idx;
    rx_msgs_valid |-> rx_msgs.slot_idx == rn_q && rx_msgs.first_seq == sq_q;
  endproperty
  a_rx_idx: assert property (p_rx_idx) else $error("rx order lost");
  property p_rx_hdr;
    rx_msgs_valid && rx_msgs.slot_idx != 2'h0 |-> rx_msgs.hdr == '0;
  endproperty
  a_rx_hdr: assert property (p_rx_hdr) else $error("header off slot 0");
  property p_addr;
    rx_msgs_valid && rx_msgs.addr_valid |-> rx_msgs.addr == {rx_msgs.msg[0][54:8], 5'h00};
  endproperty
  a_addr: assert property (p_addr) else $error("address bits wrong");
  property p_err;
    rx_msgs_valid && rx_msgs.fmt_err |-> rx_msgs.lane_valid == 4'h0;
  endproperty
  a_err: assert property (p_err) else $error("lanes on bad format");
endmodule : flit_slot_packer_sva

bind flit_slot_packer flit_slot_packer_sva chk (.ref_clk, .sys_rst, .tx_valid, .tx_ready,
  .tx_slot_valid, .tx_slot_ready, .tx_slot, .rx_slot_valid, .rx_slot_ready, .rx_msgs_valid,
  .rx_msgs_ready, .rx_msgs);

`default_nettype wire

// file: testbench/link_peer.sv
// Peer link layer model: sinks outbound slots and sources inbound slots.
`timescale 1ns/1ps
`default_nettype none

module link_peer
  import flit_pkg::*;
(
  input wire logic ref_clk, // Clock.
  input wire logic stall, // Hold off outbound slots.
  input wire logic tx_slot_valid, // Slot offered.
  output logic tx_slot_ready, // Slot taken.
  input wire slot_t tx_slot, // Slot in.
  output logic rx_slot_valid, // Slot offered.
  input wire logic rx_slot_ready, // Slot taken.
  output slot_t rx_slot // Slot out.
);
  slot_t q[$];

  assign tx_slot_ready = !stall;

  always @(posedge ref_clk)
    if (tx_slot_valid && tx_slot_ready)
      q.push_back(tx_slot);

  initial
  begin
    rx_slot_valid = 1'b0;
    rx_slot = '0;
  end

  // Once taken the lines show the inverse, so stale data cannot pass for a new slot.
  task automatic send(input slot_t s);
    @(negedge ref_clk);
    rx_slot_valid = 1'b1;
    rx_slot = s;
    @(posedge ref_clk);
    while (!rx_slot_ready)
      @(posedge ref_clk);
    @(negedge ref_clk);
    rx_slot_valid = 1'b0;
    rx_slot = ~s;
  endtask : send
endmodule : link_peer

`default_nettype wire

// file: testbench/tb_flit_slot_packer.sv
// Self-checking testbench for the flit slot packer.
`timescale 1ns/1ps
`default_nettype none

module tb_flit_slot_packer
  import flit_pkg::*;
  ;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic tx_valid = 1'b0;
  logic tx_ready;
  slot_req_t tx_req = '0;
  logic tx_slot_valid;
  logic tx_slot_ready;
  slot_t tx_slot;
  logic rx_slot_valid;
  logic rx_slot_ready;
  slot_t rx_slot;
  logic rx_msgs_valid;
  logic rx_msgs_ready = 1'b0;
  slot_msgs_t rx_msgs;
  logic stall = 1'b0;
  int fails = 0;
  int cmp_count = 0;
  localparam int WO[6][4] = '{'{20, 16, 16, 28}, '{64, 20, 0, 0}, '{20, 20, 20, 36},
    '{40, 28, 0, 0}, '{28, 28, 0, 0}, '{40, 40, 0, 0}};
  localparam int WI[6][4] = '{'{64, 32, 0, 0}, '{24, 32, 32, 0}, '{64, 24, 0, 0},
    '{24, 24, 24, 24}, '{80, 0, 0, 0}, '{72, 0, 0, 0}};

  always #4 ref_clk = ~ref_clk;

  flit_slot_packer uut (.ref_clk, .sys_rst, .tx_valid, .tx_ready, .tx_req, .tx_slot_valid,
    .tx_slot_ready, .tx_slot, .rx_slot_valid, .rx_slot_ready, .rx_slot, .rx_msgs_valid,
    .rx_msgs_ready, .rx_msgs);
  link_peer peer (.ref_clk, .stall, .tx_slot_valid, .tx_slot_ready, .tx_slot,
    .rx_slot_valid, .rx_slot_ready, .rx_slot);

  function automatic int wid(bit outb, logic [2:0] f, int l);
    if (f > 3'h5)
      return 0;
    return outb ? WO[f][l] : WI[f][l];
  endfunction : wid

  function automatic msg_t pat(logic [31:0] k);
    return {32'h0123_4567 + k, 32'h89AB_CDEF ^ k, 32'h1357_9BDF - k};
  endfunction : pat

  function automatic logic [31:0] hbits(flit_hdr_t h);
    return {4'h0, h.data_crd, h.rsp_crd, h.req_crd, h.slot_fmt, h.sz, h.be, h.ack,
      h.flit_type};
  endfunction : hbits

  // Lanes sit back to back from the base, each field low bit first.
  function automatic slot_t pack(bit outb, logic [2:0] f, logic [31:0] k, int base);
    slot_t s;
    int p;
    msg_t m;
    s = '0;
    p = base;
    for (int l = 0; l < 4; l++)
    begin
      m = pat(k + l);
      for (int b = 0; b < wid(outb, f, l); b++)
        s[p + b] = m[b];
      p += wid(outb, f, l);
    end
    return s;
  endfunction : pack

  task automatic chk_val(logic [127:0] g, logic [127:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_val

  task automatic chk_msgs(slot_msgs_t g, slot_msgs_t e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_msgs

  task automatic put_tx(slot_req_t r);
    @(negedge ref_clk);
    tx_valid = 1'b1;
    tx_req = r;
    @(posedge ref_clk);
    for (int n = 0; !tx_ready && n < 50; n++)
      @(posedge ref_clk);
    @(negedge ref_clk);
    tx_valid = 1'b0;
  endtask : put_tx

  task automatic get_tx(slot_t e);
    for (int n = 0; peer.q.size() == 0 && n < 50; n++)
      @(negedge ref_clk);
    chk_val(peer.q.size() != 0 ? peer.q.pop_front() : 'x, e);
  endtask : get_tx

  task automatic get_rx(slot_msgs_t e);
    @(negedge ref_clk);
    for (int n = 0; !rx_msgs_valid && n < 50; n++)
      @(negedge ref_clk);
    chk_msgs(rx_msgs, e);
    rx_msgs_ready = 1'b1;
    @(negedge ref_clk);
    rx_msgs_ready = 1'b0;
  endtask : get_rx

  // Slots go in pairs so one waits in the buffer; a stalled peer must leave no room.
  task automatic t_tx(flit_hdr_t h, logic [31:0] k, bit st);
    slot_req_t r;
    slot_t e[4];
    for (int i = 0; i < 4; i++)
    begin
      r.hdr = h;
      if (i != 0)
        r.hdr = ~h;
      for (int l = 0; l < 4; l++)
        r.msg[l] = pat(k + 4 * i + l);
      e[i] = pack(1'b1, h.slot_fmt[i], k + 4 * i, i == 0 ? 32 : 0);
      if (i == 0)
        e[i][31:0] = hbits(h);
      stall = st;
      put_tx(r);
      if (i[0])
      begin
        chk_val(tx_ready, !st);
        stall = 1'b0;
        get_tx(e[i - 1]);
        get_tx(e[i]);
      end
    end
    $display("tx flit %h done", h.slot_fmt);
  endtask : t_tx

  task automatic t_rx(flit_hdr_t h, logic [31:0] k, logic [7:0] sq);
    slot_msgs_t e[4];
    slot_t s;
    logic [2:0] f;
    for (int i = 0; i < 4; i++)
    begin
      f = h.slot_fmt[i];
      s = pack(1'b0, f, k + 4 * i, i == 0 ? 32 : 0);
      e[i] = '0;
      if (i == 0)
      begin
        s[31:0] = hbits(h);
        e[i].hdr = h;
      end
      e[i].slot_idx = 2'(i);
      e[i].fmt_err = f > 3'h5;
      e[i].first_seq = sq;
      for (int l = 0; l < 4; l++)
        if (wid(1'b0, f, l) > 0)
        begin
          e[i].lane_valid[l] = 1'b1;
          e[i].msg[l] = pat(k + 4 * i + l) & ((msg_t'(1) << wid(1'b0, f, l)) - 1);
          sq++;
        end
      e[i].addr_valid = f == 3'h5;
      e[i].addr = {e[i].msg[0][54:8], 5'h00};
      peer.send(s);
      if (i[0])
      begin
        chk_val(rx_slot_ready, 1'b0);
        get_rx(e[i - 1]);
        get_rx(e[i]);
      end
    end
    $display("rx flit %h done", h.slot_fmt);
  endtask : t_rx

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // Traffic needs under a hundred cycles; the limit of 5000 cycles leaves wide slack.
  initial
  begin
    #40000;
    fails++;
    results();
  end

  initial
  begin
    repeat (16)
      @(negedge ref_clk);
    chk_val({tx_ready, rx_slot_ready, tx_slot_valid, rx_msgs_valid}, 4'hC);
    sys_rst = 1'b0;
    $display("reset done");
    t_tx(flit_hdr_t'{1'b1, 1'b0, 1'b1, 1'b0, {3'h4, 3'h3, 3'h1, 3'h0}, 4'hA, 4'h5, 4'hC},
      32'h0, 1'b0);
    t_tx(flit_hdr_t'{1'b0, 1'b1, 1'b0, 1'b1, {3'h5, 3'h7, 3'h6, 3'h2}, 4'h3, 4'hF, 4'h0},
      32'h64, 1'b1);
    t_rx(flit_hdr_t'{1'b1, 1'b1, 1'b0, 1'b0, {3'h3, 3'h6, 3'h5, 3'h1}, 4'h1, 4'h2, 4'h8},
      32'hC8, 8'h00);
    t_rx(flit_hdr_t'{1'b0, 1'b0, 1'b1, 1'b1, {3'h3, 3'h4, 3'h2, 3'h0}, 4'hE, 4'h7, 4'h9},
      32'h12C, 8'h08);
    results();
  end
endmodule : tb_flit_slot_packer

`default_nettype wire
